// ### logic/hpfc_defs.svh
`ifndef HPFC_DEFS_SVH
`define HPFC_DEFS_SVH

// ****************************************************************
// synchroniser vector layout
// ****************************************************************
`define HPFC_SY_WIDTH 7
`define HPFC_SY_SEL 0
`define HPFC_SY_CS 1
`define HPFC_SY_A1 2
`define HPFC_SY_DRST 3
`define HPFC_SY_OE0 4
`define HPFC_SY_OE1 5
`define HPFC_SY_TGL 6
// strap high, chip select idle, device reset held, both enables idle
// holding device reset keeps strap capture off until the synchroniser has settled
`define HPFC_SY_RST_VAL 7'h33

// ****************************************************************
// reset values and counts
// ****************************************************************
`define HPFC_FOUR_WIRE_RST 1'b1
`define HPFC_OE1_MASK_RST 1'b0
`define HPFC_OE0_MASK_RST 1'b1
`define HPFC_BYTE_LAST 3'h7
`define HPFC_READ_BIT 7
// cycles from reset release to strap capture: the three synchroniser stages
`define HPFC_STRAP_WAIT 2'h3

`endif

// ### logic/hpfc_pkg.sv
package hpfc_pkg;
    // serial port protocol taken from the strap
    typedef enum logic {HPFC_MODE_SPI, HPFC_MODE_I2C} hpfc_mode_t;
    // phase of a frame on the link side
    typedef enum logic [1:0] {HPFC_PH_CMD, HPFC_PH_WRITE, HPFC_PH_READ} hpfc_phase_t;
endpackage

// ### logic/hpfc_sync_if.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// carrier between pin synchroniser and its user
// ****************************************************************
interface hpfc_sync_if #(parameter int WIDTH = 7);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] clean;
    modport sync_side (input raw, output clean);
    modport user_side (output raw, input clean);
endinterface
`default_nettype wire

// ### logic/hpfc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// three stage synchroniser, change accepted when stages 2 and 3 agree
// ****************************************************************
module hpfc_sync
    import hpfc_pkg::*;
#(
    parameter int WIDTH = 7,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins in, clean levels out
    hpfc_sync_if.sync_side sif
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, clean_reg;
    logic [WIDTH-1:0] s1_next, s2_next, s3_next, clean_next;

    // per bit: stage 1 only feeds stage 2
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_comb
            begin
                s1_next[i] = sif.raw[i];
                s2_next[i] = s1_reg[i];
                s3_next[i] = s2_reg[i];
                clean_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : clean_reg[i];
            end
        end
    endgenerate

    // registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            clean_reg <= RST_VAL;
        end
        else
        begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            clean_reg <= clean_next;
        end
    end

    assign sif.clean = clean_reg;
endmodule
`default_nettype wire

// ### logic/hpfc_top.sv
// Contract
// - strap high selects I2C, strap low selects SPI.
// - serial clock pin is always an input in both modes.
// - 3-wire SPI: data pin both receives and drives read data.
// - 4-wire SPI: data pin is receive-only, never driven.
// - I2C drives data pin open-drain; SPI drives push-pull.
// - I2C: second pin sampled as address bit 1, never driven.
// - 4-wire SPI: second pin drives read data push-pull.
// - I2C: first pin sampled as address bit 0.
// - SPI: first pin is active-low chip select framing transactions.
// - interrupt output goes low when status has changed.
// - reset pin low resets all internal logic to known state; the register behind rx_byte is kept unless the reset flips the toggle, which loads 8'h00.
// - reset restores all configuration to defaults.
// - all clock outputs disabled while reset is in effect.
// - primary enable low enables its outputs, high disables them.
// - after reset primary enable governs every output.
// - configuration can restrict primary enable to a subset.
// - secondary enable has no effect until configured for a subset.
`timescale 1ns/1ns
`default_nettype none
`include "hpfc_defs.svh"

module hpfc_top
    import hpfc_pkg::*;
#(
    parameter int N_OUT = 8,
    parameter int STATUS_W = 8
)
(
    // clocks and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic serial_clk,
    // strap and dual-function pins
    input wire logic i2c_sel_pin,
    input wire logic addr0_or_chip_select_pin,
    input wire logic addr1_or_serial_out_pin_in,
    output logic addr1_or_serial_out_pin_out,
    output logic addr1_or_serial_out_pin_oe,
    // shared data pin
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    // control pins
    input wire logic device_reset_n,
    input wire logic primary_output_enable_n,
    input wire logic secondary_output_enable_n,
    output logic status_change_irq_n,
    // configuration
    input wire logic cfg_wr,
    input wire logic cfg_four_wire,
    input wire logic [N_OUT-1:0] cfg_oe0_mask,
    input wire logic [N_OUT-1:0] cfg_oe1_mask,
    // status and data
    input wire logic [STATUS_W-1:0] status_in,
    input wire logic irq_clear,
    input wire logic [7:0] read_data,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    // state
    output logic mode_is_i2c,
    output logic four_wire,
    output logic [1:0] i2c_addr,
    output logic [N_OUT-1:0] out_clk_en,
    output logic device_in_reset
);
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    hpfc_sync_if #(.WIDTH(`HPFC_SY_WIDTH)) sy_if ();
    logic rx_tgl_reg;
    logic [7:0] rx_hold_reg;

    assign sy_if.raw = {rx_tgl_reg, secondary_output_enable_n, primary_output_enable_n, device_reset_n,
                        addr1_or_serial_out_pin_in, addr0_or_chip_select_pin, i2c_sel_pin};

    hpfc_sync #(.WIDTH(`HPFC_SY_WIDTH), .RST_VAL(`HPFC_SY_RST_VAL)) u_sync (
        .clk(sys_clk),
        .rst(rst),
        .sif(sy_if.sync_side)
    );

    // ****************************************************************
    // system domain state
    // ****************************************************************
    hpfc_mode_t mode_reg, mode_next;
    logic [1:0] strap_cnt_reg, strap_cnt_next;
    logic four_wire_reg, four_wire_next;
    logic [N_OUT-1:0] oe0_mask_reg, oe0_mask_next;
    logic [N_OUT-1:0] oe1_mask_reg, oe1_mask_next;
    logic [N_OUT-1:0] clk_en_reg, clk_en_next;
    logic in_reset_reg, in_reset_next;
    logic [STATUS_W-1:0] status_prev_reg, status_prev_next;
    logic pending_reg, pending_next;
    logic irq_n_reg, irq_n_next;
    logic tgl_seen_reg, tgl_seen_next;
    logic [7:0] rx_byte_reg, rx_byte_next;
    logic rx_valid_reg, rx_valid_next;
    logic [1:0] addr_reg, addr_next;
    logic [7:0] tx_word_reg, tx_word_next;
    logic status_changed;

    // next values for the system domain
    always_comb
    begin
        in_reset_next = ~sy_if.clean[`HPFC_SY_DRST];
        mode_next = mode_reg;
        strap_cnt_next = strap_cnt_reg;
        four_wire_next = four_wire_reg;
        oe0_mask_next = oe0_mask_reg;
        oe1_mask_next = oe1_mask_reg;
        // strap caught once the synchroniser has settled after reset
        if (in_reset_reg)
            strap_cnt_next = 2'h0;
        else if (strap_cnt_reg != `HPFC_STRAP_WAIT)
            strap_cnt_next = strap_cnt_reg + 2'h1;
        if (strap_cnt_reg == `HPFC_STRAP_WAIT - 2'h1)
            mode_next = sy_if.clean[`HPFC_SY_SEL] ? HPFC_MODE_I2C : HPFC_MODE_SPI;
        // configuration writes, defaults while in reset
        if (in_reset_reg)
        begin
            four_wire_next = `HPFC_FOUR_WIRE_RST;
            oe0_mask_next = {N_OUT{`HPFC_OE0_MASK_RST}};
            oe1_mask_next = {N_OUT{`HPFC_OE1_MASK_RST}};
        end
        else if (cfg_wr)
        begin
            four_wire_next = cfg_four_wire;
            oe0_mask_next = cfg_oe0_mask;
            oe1_mask_next = cfg_oe1_mask;
        end
        // output enables: low level on a pin enables its assigned outputs
        if (in_reset_reg)
            clk_en_next = '0;
        else
            clk_en_next = (oe0_mask_reg & {N_OUT{~sy_if.clean[`HPFC_SY_OE0]}})
                        | (oe1_mask_reg & {N_OUT{~sy_if.clean[`HPFC_SY_OE1]}});
        // status change: set wins over clear
        status_prev_next = status_in;
        status_changed = (status_in != status_prev_reg);
        if (in_reset_reg)
            pending_next = 1'b0;
        else
            pending_next = status_changed | (pending_reg & ~irq_clear);
        irq_n_next = ~pending_next;
        // received byte handed over by toggle, link holds the word stable
        tgl_seen_next = sy_if.clean[`HPFC_SY_TGL];
        rx_valid_next = (tgl_seen_reg != sy_if.clean[`HPFC_SY_TGL]);
        rx_byte_next = rx_valid_next ? rx_hold_reg : rx_byte_reg;
        // address pins only mean something in I2C mode
        if (mode_reg == HPFC_MODE_I2C)
            addr_next = {sy_if.clean[`HPFC_SY_A1], sy_if.clean[`HPFC_SY_CS]};
        else
            addr_next = 2'h0;
        tx_word_next = read_data;
    end

    // system domain registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_reg <= HPFC_MODE_I2C;
            strap_cnt_reg <= 2'h0;
            four_wire_reg <= `HPFC_FOUR_WIRE_RST;
            oe0_mask_reg <= {N_OUT{`HPFC_OE0_MASK_RST}};
            oe1_mask_reg <= {N_OUT{`HPFC_OE1_MASK_RST}};
            clk_en_reg <= '0;
            in_reset_reg <= 1'b1;
            status_prev_reg <= '0;
            pending_reg <= 1'b0;
            irq_n_reg <= 1'b1;
            tgl_seen_reg <= 1'b0;
            rx_byte_reg <= 8'h00;
            rx_valid_reg <= 1'b0;
            addr_reg <= 2'h0;
            tx_word_reg <= 8'h00;
        end
        else
        begin
            mode_reg <= mode_next;
            strap_cnt_reg <= strap_cnt_next;
            four_wire_reg <= four_wire_next;
            oe0_mask_reg <= oe0_mask_next;
            oe1_mask_reg <= oe1_mask_next;
            clk_en_reg <= clk_en_next;
            in_reset_reg <= in_reset_next;
            status_prev_reg <= status_prev_next;
            pending_reg <= pending_next;
            irq_n_reg <= irq_n_next;
            tgl_seen_reg <= tgl_seen_next;
            rx_byte_reg <= rx_byte_next;
            rx_valid_reg <= rx_valid_next;
            addr_reg <= addr_next;
            tx_word_reg <= tx_word_next;
        end
    end

    // ****************************************************************
    // link domain on the host's serial clock
    // ****************************************************************
    logic lk_cfg_rst;
    logic link_arst;
    logic [1:0] lk_i2c_reg, lk_i2c_next;
    logic [1:0] lk_4w_reg, lk_4w_next;
    hpfc_phase_t phase_reg, phase_next;
    logic [2:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] rx_sh_reg, rx_sh_next;
    logic [7:0] rx_hold_next;
    logic rx_tgl_next;
    logic [7:0] tx_sh_reg, tx_sh_next;
    logic d_out_reg, d_out_next, d_oe_reg, d_oe_next;
    logic s_out_reg, s_out_next, s_oe_reg, s_oe_next;
    logic drive;

    // frame logic restarts while chip select is idle in SPI mode
    assign lk_cfg_rst = rst | in_reset_reg;
    assign link_arst = lk_cfg_rst | ((mode_reg == HPFC_MODE_SPI) & addr0_or_chip_select_pin);

    // mode levels into the link domain, two flops each
    always_comb
    begin
        lk_i2c_next = {lk_i2c_reg[0], (mode_reg == HPFC_MODE_I2C)};
        lk_4w_next = {lk_4w_reg[0], four_wire_reg};
    end

    always_ff @(posedge serial_clk or posedge lk_cfg_rst)
    begin
        if (lk_cfg_rst)
        begin
            lk_i2c_reg <= 2'h0;
            lk_4w_reg <= 2'h0;
        end
        else
        begin
            lk_i2c_reg <= lk_i2c_next;
            lk_4w_reg <= lk_4w_next;
        end
    end

    // shift in host bits, shift out read data after a read command
    always_comb
    begin
        rx_sh_next = {rx_sh_reg[6:0], serial_data_pin_in};
        bit_cnt_next = bit_cnt_reg + 3'h1;
        rx_hold_next = rx_hold_reg;
        rx_tgl_next = rx_tgl_reg;
        phase_next = phase_reg;
        tx_sh_next = {tx_sh_reg[6:0], 1'b0};
        if (bit_cnt_reg == `HPFC_BYTE_LAST)
        begin
            rx_hold_next = rx_sh_next;
            rx_tgl_next = ~rx_tgl_reg;
            tx_sh_next = tx_word_reg;
            case (phase_reg)
                HPFC_PH_CMD: phase_next = rx_sh_next[`HPFC_READ_BIT] ? HPFC_PH_READ : HPFC_PH_WRITE;
                HPFC_PH_WRITE: phase_next = HPFC_PH_WRITE;
                HPFC_PH_READ: phase_next = HPFC_PH_READ;
                default: phase_next = HPFC_PH_CMD;
            endcase
        end
        drive = (phase_next == HPFC_PH_READ);
        d_out_next = 1'b0;
        d_oe_next = 1'b0;
        s_out_next = 1'b0;
        s_oe_next = 1'b0;
        if (lk_i2c_reg[1])
            d_oe_next = drive & ~tx_sh_next[7];
        else if (lk_4w_reg[1])
        begin
            s_out_next = tx_sh_next[7];
            s_oe_next = drive;
        end
        else
        begin
            d_out_next = tx_sh_next[7];
            d_oe_next = drive;
        end
    end

    // link registers, cleared between SPI frames
    always_ff @(posedge serial_clk or posedge link_arst)
    begin
        if (link_arst)
        begin
            phase_reg <= HPFC_PH_CMD;
            bit_cnt_reg <= 3'h0;
            rx_sh_reg <= 8'h00;
            tx_sh_reg <= 8'h00;
            d_out_reg <= 1'b0;
            d_oe_reg <= 1'b0;
            s_out_reg <= 1'b0;
            s_oe_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= phase_next;
            bit_cnt_reg <= bit_cnt_next;
            rx_sh_reg <= rx_sh_next;
            tx_sh_reg <= tx_sh_next;
            d_out_reg <= d_out_next;
            d_oe_reg <= d_oe_next;
            s_out_reg <= s_out_next;
            s_oe_reg <= s_oe_next;
        end
    end

    // handover word and toggle survive the end of a frame
    always_ff @(posedge serial_clk or posedge lk_cfg_rst)
    begin
        if (lk_cfg_rst)
        begin
            rx_hold_reg <= 8'h00;
            rx_tgl_reg <= 1'b0;
        end
        else
        begin
            rx_hold_reg <= rx_hold_next;
            rx_tgl_reg <= rx_tgl_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign serial_data_pin_out = d_out_reg;
    assign serial_data_pin_oe = d_oe_reg;
    assign addr1_or_serial_out_pin_out = s_out_reg;
    assign addr1_or_serial_out_pin_oe = s_oe_reg;
    assign status_change_irq_n = irq_n_reg;
    assign rx_byte = rx_byte_reg;
    assign rx_valid = rx_valid_reg;
    assign mode_is_i2c = (mode_reg == HPFC_MODE_I2C);
    assign four_wire = four_wire_reg;
    assign i2c_addr = addr_reg;
    assign out_clk_en = clk_en_reg;
    assign device_in_reset = in_reset_reg;
endmodule
`default_nettype wire

// ### verif/hpfc_top_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// pin and state checks at the block boundary
// ****************************************************************
module hpfc_top_sva
    import hpfc_pkg::*;
#(
    parameter int N_OUT = 8,
    parameter int STATUS_W = 8
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pins
    input wire logic addr0_or_chip_select_pin,
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe,
    input wire logic addr1_or_serial_out_pin_oe,
    input wire logic status_change_irq_n,
    // control and state
    input wire logic [STATUS_W-1:0] status_in,
    input wire logic irq_clear,
    input wire logic cfg_wr,
    input wire logic cfg_four_wire,
    input wire logic mode_is_i2c,
    input wire logic four_wire,
    input wire logic [N_OUT-1:0] out_clk_en,
    input wire logic device_in_reset
);
    // one domain, quiet during reset
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    property p_spi4_no_sdio;
        (!mode_is_i2c && four_wire) |-> !serial_data_pin_oe;
    endproperty
    a_spi4_no_sdio: assert property (p_spi4_no_sdio) else $error("data pin driven in 4-wire");
    property p_i2c_pull_low;
        mode_is_i2c |-> !serial_data_pin_out;
    endproperty
    a_i2c_pull_low: assert property (p_i2c_pull_low) else $error("data pin driven high in i2c");
    property p_i2c_a1_in;
        mode_is_i2c |-> !addr1_or_serial_out_pin_oe;
    endproperty
    a_i2c_a1_in: assert property (p_i2c_a1_in) else $error("second pin driven in i2c");
    property p_spi3_no_a1;
        (!mode_is_i2c && !four_wire) |-> !addr1_or_serial_out_pin_oe;
    endproperty
    a_spi3_no_a1: assert property (p_spi3_no_a1) else $error("second pin driven in 3-wire");
    property p_cs_idle;
        (!mode_is_i2c && addr0_or_chip_select_pin && $past(addr0_or_chip_select_pin))
            |-> !serial_data_pin_oe && !addr1_or_serial_out_pin_oe;
    endproperty
    a_cs_idle: assert property (p_cs_idle) else $error("pin driven with chip select high");
    property p_irq_set;
        (!device_in_reset && status_in != $past(status_in)) |=> !status_change_irq_n;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("status change without interrupt");
    property p_irq_clr;
        (!device_in_reset && irq_clear && status_in == $past(status_in)) |=> status_change_irq_n;
    endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared");
    property p_rst_off;
        (device_in_reset && $past(device_in_reset)) |-> out_clk_en == '0 && four_wire;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("outputs or wiring not reset");
    property p_cfg_wire;
        (cfg_wr && !device_in_reset) |=> four_wire == $past(cfg_four_wire);
    endproperty
    a_cfg_wire: assert property (p_cfg_wire) else $error("wiring setting not loaded");
    // main scenarios reached
    c_cfg: cover property (cfg_wr && !cfg_four_wire);
    c_irq: cover property ($fell(status_change_irq_n));
    c_sdio: cover property (serial_data_pin_oe && !mode_is_i2c);
    c_sdo: cover property (addr1_or_serial_out_pin_oe);
endmodule
bind hpfc_top hpfc_top_sva #(.N_OUT(N_OUT), .STATUS_W(STATUS_W)) i_sva (.sys_clk, .rst,
    .addr0_or_chip_select_pin, .serial_data_pin_out, .serial_data_pin_oe, .addr1_or_serial_out_pin_oe,
    .status_change_irq_n, .status_in, .irq_clear, .cfg_wr, .cfg_four_wire, .mode_is_i2c, .four_wire,
    .out_clk_en, .device_in_reset);
`default_nettype wire

// ### verif/hpfc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// host serial master and the levels of the shared lines
// ****************************************************************
module hpfc_host_model
(
    // device drives
    input wire logic i2c,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic a1_out,
    input wire logic a1_oe,
    // line levels
    output logic serial_clk,
    output logic cs_pin,
    output logic sdio_lvl,
    output logic a1_lvl
);
    logic cs_n = 1'b1, host_oe = 1'b0, host_bit = 1'b0, a0_addr = 1'b0, a1_addr = 1'b0;
    logic sdio_last = 1'b0, a1_last = 1'b0;
    initial serial_clk = 1'b0;
    // chip select in spi, address bit in i2c
    assign cs_pin = i2c ? a0_addr : cs_n;
    // pull-up in i2c, a floating line shows the inverse of its last level
    always_comb
    begin
        if (i2c)
            sdio_lvl = ~(sdio_oe | (host_oe & ~host_bit));
        else
            sdio_lvl = sdio_oe ? sdio_out : host_oe ? host_bit : ~sdio_last;
        a1_lvl = i2c ? a1_addr : a1_oe ? a1_out : ~a1_last;
    end
    // last level seen on each line
    always @(posedge serial_clk)
    begin
        sdio_last <= sdio_lvl;
        a1_last <= a1_lvl;
    end
    // clock pulses with chip select high
    task automatic idle(input int n);
        repeat (n)
        begin
            #6 serial_clk = 1'b1;
            #6 serial_clk = 1'b0;
        end
    endtask
    // command byte msb first, then a read byte when bit 7 is set
    task automatic xfer(input logic [7:0] cmd, input logic on_a1, output logic [7:0] rx);
        cs_n = 1'b0;
        #30;
        host_oe = 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            host_bit = cmd[i];
            #6 serial_clk = 1'b1;
            #6 serial_clk = 1'b0;
        end
        host_oe = 1'b0;
        rx = 8'h00;
        for (int i = 7; i >= 0 && cmd[7]; i--)
        begin
            rx[i] = on_a1 ? a1_lvl : sdio_lvl;
            #6 serial_clk = 1'b1;
            #6 serial_clk = 1'b0;
        end
        #30 cs_n = 1'b1;
        #30;
    endtask
endmodule
`default_nettype wire

// ### verif/tb_host_port_pin_function_control.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) begin total_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("BAD %s expected %h seen %h", name, exp, got); end end
// ****************************************************************
// bench for the host port pin logic
// ****************************************************************
module tb_host_port_pin_function_control
    import hpfc_pkg::*;
;
    logic sys_clk = 1'b0, rst = 1'b1, strap = 1'b1, dev_rst_n = 1'b1, oe0_n = 1'b0, oe1_n = 1'b1;
    logic cfg_wr = 1'b0, cfg_fw = 1'b1, irq_clear = 1'b0;
    logic [7:0] m0 = 8'hff, m1 = 8'h00, status = 8'h00, rdata = 8'h00, cmd, rx, got_byte;
    logic serial_clk, cs_pin, sdio_lvl, a1_lvl, sdio_out, sdio_oe, a1_out, a1_oe, irq_n, rx_valid;
    logic mode_i2c, four_wire, dev_in_rst;
    logic [1:0] i2c_addr;
    logic [7:0] out_en, rx_byte;
    int num_errors = 0, total_checks = 0, cycles = 0, nrx = 0, seen;
    // 100 MHz system clock
    always #5 sys_clk = ~sys_clk;
    hpfc_top #(.N_OUT(8), .STATUS_W(8)) i_dut (.sys_clk(sys_clk), .rst(rst), .serial_clk(serial_clk),
        .i2c_sel_pin(strap), .addr0_or_chip_select_pin(cs_pin), .addr1_or_serial_out_pin_in(a1_lvl),
        .addr1_or_serial_out_pin_out(a1_out), .addr1_or_serial_out_pin_oe(a1_oe),
        .serial_data_pin_in(sdio_lvl), .serial_data_pin_out(sdio_out), .serial_data_pin_oe(sdio_oe),
        .device_reset_n(dev_rst_n), .primary_output_enable_n(oe0_n), .secondary_output_enable_n(oe1_n),
        .status_change_irq_n(irq_n), .cfg_wr(cfg_wr), .cfg_four_wire(cfg_fw), .cfg_oe0_mask(m0),
        .cfg_oe1_mask(m1), .status_in(status), .irq_clear(irq_clear), .read_data(rdata),
        .rx_byte(rx_byte), .rx_valid(rx_valid), .mode_is_i2c(mode_i2c), .four_wire(four_wire),
        .i2c_addr(i2c_addr), .out_clk_en(out_en), .device_in_reset(dev_in_rst));
    hpfc_host_model i_host (.i2c(mode_i2c), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .a1_out(a1_out),
        .a1_oe(a1_oe), .serial_clk(serial_clk), .cs_pin(cs_pin), .sdio_lvl(sdio_lvl), .a1_lvl(a1_lvl));
    // received bytes
    always @(posedge sys_clk)
    begin
        if (rx_valid === 1'b1)
        begin
            got_byte <= rx_byte;
            nrx <= nrx + 1;
        end
    end
    task automatic wn(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    // one-cycle configuration write
    task automatic cfg(input logic fw);
        cfg_fw = fw;
        cfg_wr = 1'b1;
        wn(1);
        cfg_wr = 1'b0;
    endtask
    function automatic logic [7:0] exp_en(input logic [7:0] a, input logic [7:0] b, input logic p, input logic s);
        return (a & {8{~p}}) | (b & {8{~s}});
    endfunction
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // hang guard
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            num_errors++;
            end_sim();
        end
    end
    initial
    begin
        void'($urandom(99345));
        wn(3);
        rst = 1'b0;
        wn(20);
        `CHK("four_wire", 1'b1, four_wire)
        `CHK("mode_is_i2c", 1'b1, mode_i2c)
        `CHK("out_clk_en", 8'hff, out_en)
        `CHK("irq_n", 1'b1, irq_n)
        oe0_n = 1'b1;
        oe1_n = 1'b0;
        wn(8);
        `CHK("out_clk_en", 8'h00, out_en)
        repeat (6)
        begin
            m0 = 8'($urandom);
            m1 = 8'($urandom);
            cfg(1'b1);
            oe0_n = 1'($urandom);
            oe1_n = 1'($urandom);
            wn(8);
            `CHK("out_clk_en", exp_en(m0, m1, oe0_n, oe1_n), out_en)
        end
        $display("test enables done");
        status = status ^ (8'($urandom) | 8'h01);
        wn(2);
        `CHK("irq_n", 1'b0, irq_n)
        irq_clear = 1'b1;
        wn(1);
        irq_clear = 1'b0;
        wn(2);
        `CHK("irq_n", 1'b1, irq_n)
        $display("test interrupt done");
        cfg(1'b0);
        dev_rst_n = 1'b0;
        wn(8);
        `CHK("device_in_reset", 1'b1, dev_in_rst)
        `CHK("out_clk_en", 8'h00, out_en)
        dev_rst_n = 1'b1;
        wn(15);
        `CHK("four_wire", 1'b1, four_wire)
        `CHK("out_clk_en", exp_en(8'hff, 8'h00, oe0_n, oe1_n), out_en)
        $display("test device reset done");
        i_host.a0_addr = 1'($urandom);
        i_host.a1_addr = 1'($urandom);
        wn(8);
        `CHK("i2c_addr", {i_host.a1_addr, i_host.a0_addr}, i2c_addr)
        rdata = 8'($urandom);
        i_host.xfer(8'h80 | 8'($urandom), 1'b0, rx);
        `CHK("i2c read", rdata, rx)
        $display("test i2c done");
        strap = 1'b0;
        rst = 1'b1;
        wn(3);
        rst = 1'b0;
        wn(20);
        `CHK("mode_is_i2c", 1'b0, mode_i2c)
        cmd = 8'($urandom) & 8'h7f;
        i_host.xfer(cmd, 1'b0, rx);
        wn(10);
        `CHK("rx_byte", cmd, got_byte)
        seen = nrx;
        i_host.idle(8);
        wn(10);
        `CHK("rx count", seen, nrx)
        for (int w = 1; w >= 0; w--)
        begin
            cfg(w[0]);
            rdata = 8'($urandom);
            wn(4);
            i_host.xfer(8'h80 | 8'($urandom), w[0], rx);
            `CHK("spi read", rdata, rx)
        end
        $display("test spi done");
        end_sim();
    end
endmodule
`default_nettype wire
